// ==== core/rcc_pkg.sv ====
// Constants and types shared by the reset-cause capture block
package rcc_pkg;

    // ------------------------------------------------------------
    // Register location
    // ------------------------------------------------------------
    localparam logic [7:0] RCC_REG_ADDR  = 8'hef;
    localparam logic [7:0] RCC_REG_PAGE  = 8'h00;

    // ------------------------------------------------------------
    // Bit positions of the cause register
    // ------------------------------------------------------------
    localparam int RCC_BIT_RTC   = 7;
    localparam int RCC_BIT_FLASH = 6;
    localparam int RCC_BIT_CMP   = 5;
    localparam int RCC_BIT_SW    = 4;
    localparam int RCC_BIT_WDT   = 3;
    localparam int RCC_BIT_MCD   = 2;
    localparam int RCC_BIT_PWR   = 1;
    localparam int RCC_BIT_PIN   = 0;

    // Writable enable bits, and sources that can never be disabled
    localparam logic [7:0] RCC_EN_MASK    = 8'ha6;
    localparam logic [7:0] RCC_ALWAYS_ON  = 8'h49;
    localparam logic [7:0] RCC_EN_RESET   = 8'h00;
    localparam logic [7:0] RCC_FLAG_POR   = 8'h02;
    localparam logic [7:0] RCC_ZERO8      = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RCC_CLK_PERIOD_NS = 20;
    localparam int RCC_HOLD_NS       = 200;
    localparam int RCC_HOLD_CYC_INT  =
        (RCC_HOLD_NS + RCC_CLK_PERIOD_NS - 1) / RCC_CLK_PERIOD_NS;
    localparam logic [3:0] RCC_HOLD_CYC  = 4'(RCC_HOLD_CYC_INT);
    localparam logic [3:0] RCC_HOLD_LAST = 4'(RCC_HOLD_CYC_INT - 1);
    localparam logic [3:0] RCC_CNT_ZERO  = 4'h0;
    localparam logic [3:0] RCC_CNT_ONE   = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        RCC_ST_RUN  = 1'b0,
        RCC_ST_HOLD = 1'b1
    } rcc_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rcc_sfr_req_t;

endpackage

// ==== core/rcc_reset_cause_capture.sv ====
// Reset-cause register with source enables and system reset request
`timescale 1ns/1ps
module rcc_reset_cause_capture
    import rcc_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Special-function register access
    input  wire rcc_sfr_req_t sfrReq,
    output logic [7:0]        sfrRdata,
    // Reset sources, asynchronous levels
    input  wire logic         rtcFault,
    input  wire logic         flashFault,
    input  wire logic         cmpTrip,
    input  wire logic         wdtOverflow,
    input  wire logic         missingClock,
    input  wire logic         supplyLow,
    input  wire logic         supplyStable,
    input  wire logic         extPinReset,
    // System reset request
    output logic              sysResetOut
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [7:0] rawIn;
    logic [7:0] syncA_ff;
    logic [7:0] syncB_ff;
    logic [7:0] syncC_ff;
    logic [7:0] level_ff;
    logic [2:0] stabSync_ff;
    logic       stable_ff;

    // Bit 4 has no outside source; it only comes from a register write
    assign rawIn = {rtcFault, flashFault, cmpTrip, 1'b0,
                    wdtOverflow, missingClock, supplyLow, extPinReset};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_sync
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    syncA_ff[gi] <= 1'b0;
                    syncB_ff[gi] <= 1'b0;
                    syncC_ff[gi] <= 1'b0;
                    level_ff[gi] <= 1'b0;
                end
                else
                begin
                    syncA_ff[gi] <= rawIn[gi];
                    syncB_ff[gi] <= syncA_ff[gi];
                    syncC_ff[gi] <= syncB_ff[gi];
                    // Only a level seen twice in a row is believed
                    if (syncB_ff[gi] == syncC_ff[gi])
                        level_ff[gi] <= syncC_ff[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stabSync_ff <= 3'h0;
            stable_ff   <= 1'b0;
        end
        else
        begin
            stabSync_ff <= {stabSync_ff[1:0], supplyStable};
            if (stabSync_ff[1] == stabSync_ff[2])
                stable_ff <= stabSync_ff[2];
        end
    end

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    rcc_state_t state_ff;
    rcc_state_t nxt_state;
    logic [7:0] enable_ff;
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [3:0] holdCnt_ff;
    logic [7:0] rdata_ff;
    logic [7:0] armed;
    logic [7:0] gated;
    logic       hit;
    logic       regWrite;
    logic       swForce;
    logic       unsafePwr;

    always_comb
    begin
        if ((sfrReq.addr == RCC_REG_ADDR) && (sfrReq.page == RCC_REG_PAGE))
            hit = 1'b1;
        else
            hit = 1'b0;
    end

    // Writes are ignored while the system is held in reset
    assign regWrite  = hit && sfrReq.wr && (state_ff == RCC_ST_RUN);
    assign swForce   = regWrite && sfrReq.wdata[RCC_BIT_SW];
    assign unsafePwr = regWrite && sfrReq.wdata[RCC_BIT_PWR] && !stable_ff;

    // Disabled sources are masked; flash, watchdog and pin always reset
    assign armed = enable_ff | RCC_ALWAYS_ON;
    assign gated = level_ff & armed;

    // ------------------------------------------------------------
    // Cause selection: power wins, else the lowest set bit
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_flags = RCC_ZERO8;
        nxt_state = state_ff;
        case (state_ff)
            RCC_ST_RUN:
            begin
                if (gated[RCC_BIT_PWR] || unsafePwr)
                    nxt_flags[RCC_BIT_PWR] = 1'b1;
                else if (gated != RCC_ZERO8)
                begin
                    for (int i = 7; i >= 0; i--)
                    begin
                        if (gated[i])
                        begin
                            nxt_flags = RCC_ZERO8;
                            nxt_flags[i] = 1'b1;
                        end
                    end
                end
                else if (swForce)
                    nxt_flags[RCC_BIT_SW] = 1'b1;
                if (nxt_flags != RCC_ZERO8)
                    nxt_state = RCC_ST_HOLD;
            end
            RCC_ST_HOLD:
            begin
                if (holdCnt_ff == RCC_HOLD_LAST)
                    nxt_state = RCC_ST_RUN;
            end
            default:
                nxt_state = RCC_ST_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer state and hold counter
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_ff   <= RCC_ST_RUN;
            holdCnt_ff <= RCC_CNT_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == RCC_ST_HOLD)
                holdCnt_ff <= holdCnt_ff + RCC_CNT_ONE;
            else
                holdCnt_ff <= RCC_CNT_ZERO;
        end
    end

    assign sysResetOut = (state_ff == RCC_ST_HOLD);

    // ------------------------------------------------------------
    // Cause flags: replaced whole on every reset, never by a write
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            flags_ff <= RCC_FLAG_POR;
        else if (nxt_flags != RCC_ZERO8)
            flags_ff <= nxt_flags;
    end

    // ------------------------------------------------------------
    // Enables: a whole-byte write only touches the enable bits
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            enable_ff <= RCC_EN_RESET;
        else if (regWrite)
            enable_ff <= sfrReq.wdata & RCC_EN_MASK;
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
            rdata_ff <= RCC_ZERO8;
        else if (sfrReq.rd && hit)
            rdata_ff <= flags_ff;
        else if (sfrReq.rd)
            rdata_ff <= RCC_ZERO8;
    end

    assign sfrRdata = rdata_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb_chk @(posedge clock);
    endclocking

    default disable iff (rst);

    sequence seq_swWrite;
        (state_ff == RCC_ST_RUN) && regWrite && sfrReq.wdata[RCC_BIT_SW]
            && (gated == RCC_ZERO8) && !unsafePwr;
    endsequence

    sequence seq_quietWrite;
        (state_ff == RCC_ST_RUN) && regWrite && !sfrReq.wdata[RCC_BIT_SW]
            && (gated == RCC_ZERO8) && !unsafePwr;
    endsequence

    AST_SW_RESET: assert property (
        seq_swWrite |=> sysResetOut && (flags_ff == 8'h10))
        else $error("software force did not reset with bit 4 set");

    AST_QUIET_WRITE: assert property (
        seq_quietWrite |=> !sysResetOut && $stable(flags_ff))
        else $error("write without force changed flags or reset");

    AST_ONE_FLAG: assert property (
        $onehot(flags_ff))
        else $error("cause flags not one-hot");

    AST_HOLD_LEN: assert property (
        $fell(sysResetOut) |-> $past(holdCnt_ff) == RCC_HOLD_LAST)
        else $error("reset hold length wrong");

    // An unsafe supply enable in the same cycle outranks the watchdog
    AST_WDT_FLAG: assert property (
        (state_ff == RCC_ST_RUN) && (gated == 8'h08) && !unsafePwr |=>
            sysResetOut && (flags_ff == 8'h08))
        else $error("watchdog cause not captured");

    AST_EN_WRITE: assert property (
        regWrite |=> enable_ff == ($past(sfrReq.wdata) & RCC_EN_MASK))
        else $error("enable bits not taken from write");

    AST_READBACK: assert property (
        sfrReq.rd && hit |=> sfrRdata == $past(flags_ff))
        else $error("read data does not match flags");

    AST_UNSAFE_PWR: assert property (
        (state_ff == RCC_ST_RUN) && unsafePwr |=>
            sysResetOut && (flags_ff == 8'h02))
        else $error("unstable supply enable did not reset");

    AST_MCD_OFF: assert property (
        (state_ff == RCC_ST_RUN) && !enable_ff[RCC_BIT_MCD]
            && (level_ff == 8'h04) && !regWrite |=> !sysResetOut)
        else $error("disabled missing-clock detector caused reset");

    AST_HOLD_STAYS: assert property (
        $rose(sysResetOut) |-> sysResetOut[*8] ##[1:3] !sysResetOut)
        else $error("reset pulse too short or too long");

endmodule // rcc_reset_cause_capture

// ==== dv/rcc_reset_cause_capture_bench.sv ====
// Self-checking testbench for the reset-cause capture block
`timescale 1ns/1ps
module rcc_reset_cause_capture_bench
    import rcc_pkg::*;
;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic         clock;
    logic         rst;
    rcc_sfr_req_t sfrReq;
    logic [7:0]   sfrRdata;
    logic [6:0]   cause;
    logic         supplyStable;
    logic         sysResetOut;
    int           error_cnt;
    int           compares;

    rcc_reset_cause_capture i_dut (
        .clock        (clock),
        .rst          (rst),
        .sfrReq       (sfrReq),
        .sfrRdata     (sfrRdata),
        .rtcFault     (cause[0]),
        .flashFault   (cause[1]),
        .cmpTrip      (cause[2]),
        .wdtOverflow  (cause[3]),
        .missingClock (cause[4]),
        .supplyLow    (cause[5]),
        .supplyStable (supplyStable),
        .extPinReset  (cause[6]),
        .sysResetOut  (sysResetOut)
    );

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic final_report();
        if (error_cnt == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] page,
                          input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        sfrReq = '{wr, ~wr, page, addr, data};
        @(negedge clock);
        sfrReq = '0;
    endtask

    task automatic readReg(input logic [7:0] page, input logic [7:0] addr,
                           input logic [7:0] exp);
        access(1'b0, page, addr, RCC_ZERO8);
        chk("read data", exp, sfrRdata);
    endtask

    // Cause is dropped as soon as the hold starts so no second reset follows
    task automatic measure(output int len);
        len = 0;
        for (int i = 0; i < 30 && sysResetOut !== 1'b1; i++)
            @(negedge clock);
        if (sysResetOut === 1'b1)
        begin
            cause = '0;
            while (sysResetOut === 1'b1)
            begin
                len++;
                if (len > 20)
                begin
                    $display("[FAIL] hold stuck expected 0 seen 1");
                    error_cnt++;
                    final_report();
                end
                @(negedge clock);
            end
        end
    endtask

    task automatic trip(input int idx, input int expLen,
                        input logic [7:0] expFlags);
        int len;
        cause[idx] = 1'b1;
        measure(len);
        cause = '0;
        repeat (8) @(negedge clock);
        chk("hold cycles", 8'(expLen), 8'(len));
        readReg(RCC_REG_PAGE, RCC_REG_ADDR, expFlags);
    endtask

    task automatic wrMeasure(input logic [7:0] data, input int expLen,
                             input logic [7:0] expFlags);
        int len;
        access(1'b1, RCC_REG_PAGE, RCC_REG_ADDR, data);
        measure(len);
        chk("hold cycles", 8'(expLen), 8'(len));
        readReg(RCC_REG_PAGE, RCC_REG_ADDR, expFlags);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_on();
        readReg(RCC_REG_PAGE, RCC_REG_ADDR, 8'h02);
        readReg(RCC_REG_PAGE, 8'hee, 8'h00);
        readReg(8'h01, RCC_REG_ADDR, 8'h00);
    endtask

    task automatic t_software();
        wrMeasure(8'h00, 0, 8'h02);
        wrMeasure(8'h10, 10, 8'h10);
        wrMeasure(8'h49, 0, 8'h10);
    endtask

    task automatic t_always_armed();
        trip(1, 10, 8'h40);
        trip(3, 10, 8'h08);
        trip(6, 10, 8'h01);
    endtask

    task automatic t_enables();
        trip(2, 0, 8'h01);
        trip(4, 0, 8'h01);
        wrMeasure(8'h20, 0, 8'h01);
        trip(2, 10, 8'h20);
        wrMeasure(8'h24, 0, 8'h20);
        trip(4, 10, 8'h04);
        trip(2, 10, 8'h20);
        trip(0, 0, 8'h20);
        wrMeasure(8'ha4, 0, 8'h20);
        trip(0, 10, 8'h80);
        trip(5, 0, 8'h80);
    endtask

    // Enabling the monitor while unsettled must reset at once
    task automatic t_supply();
        supplyStable = 1'b0;
        repeat (8) @(negedge clock);
        wrMeasure(8'h02, 10, 8'h02);
        supplyStable = 1'b1;
        repeat (8) @(negedge clock);
        trip(6, 10, 8'h01);
        trip(5, 10, 8'h02);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        error_cnt = 0;
        compares = 0;
        rst = 1'b1;
        sfrReq = '0;
        cause = '0;
        supplyStable = 1'b1;
        repeat (8) @(negedge clock);
        rst = 1'b0;
        t_power_on();
        t_software();
        t_always_armed();
        t_enables();
        t_supply();
        final_report();
    end

endmodule // rcc_reset_cause_capture_bench
